// ### core/psmc_pkg.sv
// Purpose: Shared constants and types for the power-saving mode control
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Codes, offsets, field positions and reset values live here
package psmc_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SLEEP_STOP = 8'h00;
   localparam logic [7:0] ADDR_CLK_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_STATUS     = 8'h08;
   localparam logic [7:0] ADDR_WAKE_CTRL  = 8'h0C;
   // ----------------------------------------------------------------
   // Entry codes and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_IDLE       = 8'h0F;
   localparam logic [7:0] CODE_STOP       = 8'h5A;
   localparam int         CLK_SEL_SUB_BIT = 0;
   localparam int         MAIN_EN_BIT     = 1;
   localparam int         SUB_EN_BIT      = 2;
   localparam int         DIV_LSB         = 4;
   localparam int         DIV_W           = 3;
   localparam logic [2:0] DIV_RESET       = 3'h7;
   localparam logic [7:0] CLK_CTRL_RESET  = 8'h76;
   localparam logic [7:0] BIT_MAX         = 8'hFF;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum logic [3:0] {
      ST_RUN   = 4'h1,
      ST_IDLE  = 4'h2,
      ST_STOP  = 4'h4,
      ST_STAB  = 4'h8
   } psmc_state_t;

   typedef struct packed {
      logic cpuRun;
      logic mainOscEn;
      logic subOscEn;
      logic sysPeriphEn;
      logic subPeriphEn;
      logic holdState;
   } psmc_gate_t;
endpackage : psmc_pkg

// ### core/psmc_ctrl.sv
// Purpose: Idle/stop sequencing, oscillator gating and stabilization wait
// Assumes: Stop instruction and wake events arrive from on-chip logic
// Notes:   Stabilization counter doubles as the basic interval timer
`timescale 1ns/10ps

// Functional notes
// - Low power halts CPU, holds state; only stop gates peripherals
// - Stop halts the selected system oscillator
// - Unselected running oscillator keeps running in stop
// - Main-clocked stop keeps sub oscillator and watch
// - Stabilization wait after reset and every wake
// - Wait is one full interval timer cycle
// - Programmed divider sets wake wait length
// - Reset wait uses default divider
// - Timer cleared, counts to maximum, overflow resumes
// - Wake vectors only when interrupt flag set
module psmc_ctrl
   import psmc_pkg::*;
(
   input  wire logic        core_clk,       // 40 MHz core clock
   input  wire logic        rst_b,          // Async reset, active low
   input  wire logic [7:0]  s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [7:0]  s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready,   // Read data ready
   input  wire logic        stopInstr,      // Stop instruction executed
   input  wire logic        wakeIrq,        // Pending enabled interrupt
   input  wire logic        intFlag,        // Global interrupt enable
   output psmc_gate_t       gate_r,         // Clock and peripheral gates
   output logic             resumeNext,     // Resume at next instruction
   output logic             resumeVector    // Resume with interrupt
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   psmc_state_t state_r, stateNxt;
   logic [7:0]  sleepStop_r;
   logic [7:0]  clkCtrl_r;
   logic [7:0]  bitCnt_r;
   logic [7:0]  preCnt_r;
   logic        wakeVec_r;
   logic        awHeld_r, wHeld_r;
   logic [7:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;

   // ----------------------------------------------------------------
   // AXI4-Lite decode
   // ----------------------------------------------------------------
   wire wrFire  = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire wrSs    = wrFire && awAddr_r == ADDR_SLEEP_STOP;
   wire wrCk    = wrFire && awAddr_r == ADDR_CLK_CTRL;
   wire wrOk    = wrSs || wrCk;
   wire rdFire  = s_axi_arvalid && !s_axi_rvalid;
   wire rdSs    = s_axi_araddr == ADDR_SLEEP_STOP;
   wire rdCk    = s_axi_araddr == ADDR_CLK_CTRL;
   wire rdSt    = s_axi_araddr == ADDR_STATUS;
   wire rdOk    = rdSs || rdCk || rdSt;
   wire [31:0] rdMux = rdSs ? {24'h000000, sleepStop_r}
                     : rdCk ? {24'h000000, clkCtrl_r}
                     : rdSt ? {16'h0000, bitCnt_r, 4'h0, state_r}
                     : 32'h00000000;
   assign s_axi_awready = !awHeld_r;
   assign s_axi_wready  = !wHeld_r;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r  <= 32'h00000000;
         wStrb_r  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && !awHeld_r) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end else if (wrFire) begin
            awHeld_r <= 1'b0;
         end
         if (s_axi_wvalid && !wHeld_r) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (wrFire) begin
            wHeld_r <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   wire       selSub   = clkCtrl_r[CLK_SEL_SUB_BIT];
   wire [2:0] divSel   = clkCtrl_r[DIV_LSB +: DIV_W];
   // divider: prescale tick every 2^(div+1) cycles
   // Tick closes each period, so the first count is a full one
   wire [7:0] preMask  = 8'((9'h002 << divSel) - 9'h001);
   wire       preTick  = (preCnt_r & preMask) == preMask;
   wire       bitOvf   = preTick && bitCnt_r == BIT_MAX;
   wire       enterIdle = sleepStop_r == CODE_IDLE;
   wire       enterStop = sleepStop_r == CODE_STOP && stopInstr;

   always_comb begin
      stateNxt = state_r;
      case (state_r)
         ST_RUN:  begin
            if (enterStop) stateNxt = ST_STOP;
            else if (enterIdle) stateNxt = ST_IDLE;
         end
         ST_IDLE: if (wakeIrq) stateNxt = ST_STAB;
         ST_STOP: if (wakeIrq) stateNxt = ST_STAB;
         ST_STAB: if (bitOvf) stateNxt = ST_RUN;
         default: stateNxt = ST_STAB;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         // reset starts the wait, default divider
         state_r     <= ST_STAB;
         clkCtrl_r   <= CLK_CTRL_RESET;
         sleepStop_r <= 8'h00;
         bitCnt_r    <= 8'h00;
         preCnt_r    <= 8'h00;
         wakeVec_r   <= 1'b0;
      end else begin
         state_r <= stateNxt;
         if (wrCk && wStrb_r[0]) clkCtrl_r <= wData_r[7:0];
         if (state_r != ST_RUN && stateNxt == ST_STAB) begin
            sleepStop_r <= 8'h00;
         end else if (state_r == ST_IDLE) begin
            sleepStop_r <= 8'h00;
         end else if (wrSs && wStrb_r[0]) begin
            sleepStop_r <= wData_r[7:0];
         end
         // clear on wake, count to maximum
         if (stateNxt == ST_STAB && state_r != ST_STAB) begin
            bitCnt_r <= 8'h00;
            preCnt_r <= 8'h00;
            wakeVec_r <= intFlag;
         end else if (state_r != ST_STOP) begin
            preCnt_r <= preCnt_r + 8'h01;
            if (preTick) bitCnt_r <= bitCnt_r + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gating outputs
   // ----------------------------------------------------------------
   wire inStop = state_r == ST_STOP;
   wire lowPwr = inStop || state_r == ST_IDLE;
   wire runRes = state_r == ST_STAB && bitOvf;
   assign resumeVector = runRes && wakeVec_r;
   assign resumeNext   = runRes && !wakeVec_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_r <= '0;
      end else begin
         gate_r.cpuRun      <= stateNxt == ST_RUN;
         gate_r.holdState   <= stateNxt != ST_RUN;
         gate_r.mainOscEn   <= clkCtrl_r[MAIN_EN_BIT] &&
                               !(stateNxt == ST_STOP && !selSub);
         gate_r.subOscEn    <= clkCtrl_r[SUB_EN_BIT] &&
                               !(stateNxt == ST_STOP && selSub);
         gate_r.sysPeriphEn <= stateNxt != ST_STOP;
         gate_r.subPeriphEn <= !(stateNxt == ST_STOP && selSub);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_stop_cpu_halt: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      inStop |=> !gate_r.cpuRun && gate_r.holdState)
      else $error("CPU running during stop");
   chk_stop_main_off: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      inStop && !selSub |-> !gate_r.mainOscEn)
      else $error("Selected main oscillator not stopped");
   chk_stop_sub_kept: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      inStop && !selSub && clkCtrl_r[SUB_EN_BIT]
      |-> gate_r.subOscEn && gate_r.subPeriphEn)
      else $error("Sub oscillator stopped in main stop");
   chk_wake_wait: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      lowPwr && wakeIrq |=> state_r == ST_STAB && bitCnt_r == 8'h00)
      else $error("Wake skipped the wait");
   chk_wait_ends: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      state_r == ST_STAB && bitOvf |=> state_r == ST_RUN)
      else $error("Wait did not end on overflow");
   chk_wait_full: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $rose(state_r == ST_RUN)
      |-> $past(state_r) == ST_STAB && $past(bitCnt_r) == BIT_MAX)
      else $error("Resume before counter maximum");
   chk_resume_vec: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      lowPwr && wakeIrq |=> wakeVec_r == $past(intFlag) &&
      !(resumeNext && resumeVector))
      else $error("Vectored without interrupt flag");
   chk_code_clear: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      inStop && wakeIrq |=> sleepStop_r == 8'h00)
      else $error("Entry code kept after release");
endmodule : psmc_ctrl

// ### sim/psmc_ctrl_test.sv
// Purpose: Self-checking bench for the power-saving mode control
// Assumes: Bench acts as AXI4-Lite master; bready/rready held high
// Notes:   Small dividers keep wake waits short; reset wait is full length
`timescale 1ns/10ps
module psmc_ctrl_test;
   import psmc_pkg::*;
   logic        core_clk, rst_b, stopInstr, wakeIrq, intFlag;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, resumeNext, resumeVector;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  s_axi_wstrb;
   psmc_gate_t  gate_r;
   int          n_mismatch, checks, cyc, start;
   logic [7:0]  ctrlTab [3] = '{8'h06, 8'h07, 8'h02};

   psmc_ctrl dut (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .stopInstr(stopInstr),
      .wakeIrq(wakeIrq), .intFlag(intFlag), .gate_r(gate_r),
      .resumeNext(resumeNext), .resumeVector(resumeVector));

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Readies sampled at the falling edge, valids released right after the rising edge
   task automatic axiWr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] rsp);
      logic ta, tw, tb;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(negedge core_clk);
         ta  = s_axi_awvalid && s_axi_awready;
         tw  = s_axi_wvalid && s_axi_wready;
         tb  = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
   endtask : axiWr

   task automatic axiRd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] rsp);
      logic ta, tr;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ta  = s_axi_arvalid && s_axi_arready;
         tr  = s_axi_rvalid;
         v   = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
   endtask : axiRd

   // Kind 0 expects plain resume, 1 vectored, 2 either
   task automatic waitPulse(input int st, input int exp, input int kind);
      while (!(resumeNext || resumeVector)) @(negedge core_clk);
      chk(cyc - st == exp, 1);
      if (kind != 2)
         chk({resumeNext, resumeVector}, {~kind[0], kind[0]});
      @(posedge core_clk);
      @(posedge core_clk);
      axiRd(ADDR_STATUS, d, r);
      chk(d[3:0], 4'h1);
   endtask : waitPulse

   task automatic wakeWait(input logic flag, input int exp);
      intFlag <= flag;
      wakeIrq <= 1'b1;
      @(posedge core_clk);
      wakeIrq <= 1'b0;
      waitPulse(cyc, exp, flag);
   endtask : wakeWait

   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   initial begin
      repeat (90000) @(posedge core_clk);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end

   initial begin
      {core_clk, rst_b, stopInstr, wakeIrq, intFlag, cyc} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      start = cyc;
      @(posedge core_clk);
      axiRd(ADDR_CLK_CTRL, d, r);
      chk(r, RESP_OKAY);
      chk(d, CLK_CTRL_RESET);
      axiRd(ADDR_STATUS, d, r);
      chk(d[3:0], 4'h8);
      waitPulse(start, 65536, 2);
      $display("test reset wait done");
      // ----------------------------------------------------------------
      // Idle with divider 1
      // ----------------------------------------------------------------
      axiWr(ADDR_CLK_CTRL, 32'h16, r);
      chk(r, RESP_OKAY);
      axiWr(ADDR_SLEEP_STOP, CODE_IDLE, r);
      repeat (2) @(posedge core_clk);
      axiRd(ADDR_STATUS, d, r);
      chk(d[3:0], 4'h2);
      chk(gate_r, 6'h1F);
      wakeWait(1'b1, 1024);
      $display("test idle done");
      // ----------------------------------------------------------------
      // Stop with each clock selection
      // ----------------------------------------------------------------
      for (int i = 0; i < 3; i++) begin
         axiWr(ADDR_CLK_CTRL, {24'h0, ctrlTab[i]}, r);
         axiWr(ADDR_SLEEP_STOP, CODE_STOP, r);
         axiRd(ADDR_STATUS, d, r);
         chk(d[3:0], 4'h1);
         stopInstr <= 1'b1;
         @(posedge core_clk);
         stopInstr <= 1'b0;
         repeat (3) @(posedge core_clk);
         chk(gate_r, {1'b0, ctrlTab[i][1] & ctrlTab[i][0],
            ctrlTab[i][2] & ~ctrlTab[i][0], 1'b0,
            ~ctrlTab[i][0], 1'b1});
         wakeWait(i[0], 512);
         axiRd(ADDR_SLEEP_STOP, d, r);
         chk(d, 32'h0);
      end
      $display("test stop done");
      // ----------------------------------------------------------------
      // Refused accesses and wrong entry code
      // ----------------------------------------------------------------
      axiWr(8'h10, 32'h0, r);
      chk(r, RESP_SLVERR);
      axiWr(ADDR_STATUS, 32'h0, r);
      chk(r, RESP_SLVERR);
      axiRd(8'h14, d, r);
      chk(r, RESP_SLVERR);
      axiWr(ADDR_SLEEP_STOP, 32'h33, r);
      stopInstr <= 1'b1;
      @(posedge core_clk);
      stopInstr <= 1'b0;
      repeat (3) @(posedge core_clk);
      axiRd(ADDR_STATUS, d, r);
      chk(d[3:0], 4'h1);
      $display("test refusals done");
      results();
   end
endmodule : psmc_ctrl_test
